// ==== core/lane_cfg_pkg.sv ====
`default_nettype none

package lane_cfg_pkg;

    // register addresses of this slice of the map
    localparam logic [7:0] EQ_FIRST_ADDR       = 8'h04;
    localparam logic [7:0] EQ_BANK3_LOW_ADDR   = 8'h0C;
    localparam logic [7:0] EQ_BANK3_HIGH_ADDR  = 8'h0D;
    localparam logic [7:0] RX_PD_LOW_ADDR      = 8'h0E;
    localparam logic [7:0] RX_PD_HIGH_ADDR     = 8'h0F;
    localparam logic [7:0] TX_HIZ_LOW_ADDR     = 8'h10;
    localparam logic [7:0] TX_HIZ_HIGH_ADDR    = 8'h11;

    // array geometry
    localparam int LANES        = 16;
    localparam int EQ_WIDTH     = 5;
    localparam int EQ_BITS      = LANES * EQ_WIDTH;
    localparam int EQ_BYTES     = 10;
    localparam int EQ_KEPT_LOW  = 76;

    // values after reset
    localparam logic [4:0] EQ_RESET_CODE = 5'h08;
    localparam logic [7:0] PD_RESET_BYTE  = 8'h00;
    localparam logic [7:0] HIZ_RESET_BYTE = 8'h00;

    // static lane controls handed to the analog side
    typedef struct packed {
        logic [LANES-1:0][EQ_WIDTH-1:0] eq_setting;
        logic [LANES-1:0]               rx_powerdown;
        logic [LANES-1:0]               tx_highz;
    } lane_ctrl_t;

endpackage

`default_nettype wire

// ==== core/lane_config_register_bank.sv ====
// Operation
// - equaliser fields five bits, packed LSB first
// - bank3 channel3 field sits at 0x0D bits 7:3
// - every equaliser field resets to code 0x08
// - all codes 00..1F pass unchanged to lane
// - rx power-down bits in 0x0E and 0x0F
// - power-down bit high turns receiver off
// - reset clears all receiver power-down bits
// - tx high-z bits in 0x10 and 0x11
// - reset clears all transmitter high-z bits
// - high-z bit high floats transmitter termination
// - array starts at 0x04 bit 0, bank0 ch0
`timescale 1ns/1ps
`default_nettype none

module lane_config_register_bank
    import lane_cfg_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] rd_data,
    output logic            rd_hit,
    output lane_ctrl_t      lane_ctrl
);

    // whole packed equaliser array, 0x04..0x0D, one flat vector
    logic [EQ_BITS-1:0] eq_bits_r;
    logic [7:0]         pd_low_r;
    logic [7:0]         pd_high_r;
    logic [7:0]         hiz_low_r;
    logic [7:0]         hiz_high_r;
    logic [7:0]         rd_nxt;
    logic               hit_nxt;

    // byte index into the equaliser array, valid only when in range
    function automatic logic eq_addr_hit(input logic [7:0] a);
        return (a >= EQ_FIRST_ADDR) && (a <= EQ_BANK3_HIGH_ADDR);
    endfunction

    function automatic logic [3:0] eq_byte_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - EQ_FIRST_ADDR;
        return d[3:0];
    endfunction

    // reset pattern: 0x08 in each five-bit field
    function automatic logic [EQ_BITS-1:0] eq_reset_vec();
        logic [EQ_BITS-1:0] v;
        v = '0;
        for (int i = 0; i < LANES; i++)
        begin
            v[i*EQ_WIDTH +: EQ_WIDTH] = EQ_RESET_CODE;
        end
        return v;
    endfunction

    // equaliser array writes; byte boundaries ignore field boundaries
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            eq_bits_r <= eq_reset_vec();
        end
        else if (wr_en && eq_addr_hit(addr))
        begin
            // LSB-first packing from 0x04 bit 0
            // the bank3 ch2 field is indexed by position
            eq_bits_r[eq_byte_idx(addr)*8 +: 8] <= wr_data;
        end
    end

    // receiver power-down, banks 0 and 1; bit = ch + 4*bank
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            pd_low_r <= PD_RESET_BYTE;
        end
        else if (wr_en && addr == RX_PD_LOW_ADDR)
        begin
            pd_low_r <= wr_data;
        end
    end

    // receiver power-down, banks 2 and 3; bit = ch + 4*(bank-2)
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            pd_high_r <= PD_RESET_BYTE;
        end
        else if (wr_en && addr == RX_PD_HIGH_ADDR)
        begin
            pd_high_r <= wr_data;
        end
    end

    // transmitter termination high-z, banks 0 and 1
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            hiz_low_r <= HIZ_RESET_BYTE;
        end
        else if (wr_en && addr == TX_HIZ_LOW_ADDR)
        begin
            hiz_low_r <= wr_data;
        end
    end

    // transmitter termination high-z, banks 2 and 3
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            hiz_high_r <= HIZ_RESET_BYTE;
        end
        else if (wr_en && addr == TX_HIZ_HIGH_ADDR)
        begin
            hiz_high_r <= wr_data;
        end
    end

    // read mux; unmapped addresses read zero with no hit
    always_comb
    begin
        rd_nxt  = 8'h00;
        hit_nxt = 1'b1;
        if (eq_addr_hit(addr))
        begin
            rd_nxt = eq_bits_r[eq_byte_idx(addr)*8 +: 8];
        end
        else
        begin
            case (addr)
                RX_PD_LOW_ADDR:   rd_nxt = pd_low_r;
                RX_PD_HIGH_ADDR:  rd_nxt = pd_high_r;
                TX_HIZ_LOW_ADDR:  rd_nxt = hiz_low_r;
                TX_HIZ_HIGH_ADDR: rd_nxt = hiz_high_r;
                default:          hit_nxt = 1'b0;
            endcase
        end
    end

    // registered read data, one cycle after rd_en; held between
    // reads so a slow host may sample it late
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            rd_data <= 8'h00;
        end
        else if (rd_en)
        begin
            rd_data <= rd_nxt;
        end
    end

    // mapped flag for the last read, same timing as the data
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            rd_hit <= 1'b0;
        end
        else if (rd_en)
        begin
            rd_hit <= hit_nxt;
        end
    end

    // lane controls come from flops; one cycle behind the stores so
    // the analog side never sees a combinational glitch
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            lane_ctrl.eq_setting <= eq_reset_vec();
        end
        else
        begin
            lane_ctrl.eq_setting <= eq_bits_r;
        end
    end

    // 1 = receiver off, bit = ch + 4*bank
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            lane_ctrl.rx_powerdown <= {PD_RESET_BYTE, PD_RESET_BYTE};
        end
        else
        begin
            lane_ctrl.rx_powerdown <= {pd_high_r, pd_low_r};
        end
    end

    // 1 = termination floated; 0 keeps the normal load
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            lane_ctrl.tx_highz <= {HIZ_RESET_BYTE, HIZ_RESET_BYTE};
        end
        else
        begin
            lane_ctrl.tx_highz <= {hiz_high_r, hiz_low_r};
        end
    end

endmodule

`default_nettype wire

// ==== verification/lane_cfg_bank_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module bank_checker
    import lane_cfg_pkg::*;
(
    input wire logic       mclk,
    input wire logic       reset,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic       rd_hit,
    input wire lane_ctrl_t lane_ctrl
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // a write reaches the lane outputs two edges on
    sequence s_wr(a); wr_en && addr == a; endsequence
    property p_eq; s_wr(8'h0D) |=> ##1
        lane_ctrl.eq_setting[15] == 5'($past(wr_data, 2) >> 3); endproperty
    a_eq: assert property (p_eq) else $error("eq");
    property p_pd; s_wr(8'h0F) |=> ##1
        lane_ctrl.rx_powerdown[15:8] == $past(wr_data, 2); endproperty
    a_pd: assert property (p_pd) else $error("pd");
    property p_hz; s_wr(8'h10) |=> ##1
        lane_ctrl.tx_highz[7:0] == $past(wr_data, 2); endproperty
    a_hz: assert property (p_hz) else $error("hz");
    property p_rs; $fell(reset) |->
        lane_ctrl == {{LANES{EQ_RESET_CODE}}, 32'h0}; endproperty
    a_rs: assert property (p_rs) else $error("rst");
    property p_lo; s_wr(8'h04) |=> ##1
        lane_ctrl.eq_setting[0] == $past(wr_data[4:0], 2); endproperty
    a_lo: assert property (p_lo) else $error("eq lo");
    property p_rd; rd_en && addr inside {[8'h04:8'h11]} |=> rd_hit; endproperty
    a_rd: assert property (p_rd) else $error("hit");
    property p_un; rd_en && addr > 8'h11 |=> {rd_hit, rd_data} == 9'h0;
    endproperty
    a_un: assert property (p_un) else $error("unmapped");
    property p_st; !wr_en |=> ##1 $stable(lane_ctrl); endproperty
    a_st: assert property (p_st) else $error("held");
    property p_rh; !rd_en |=> $stable(rd_data); endproperty
    a_rh: assert property (p_rh) else $error("rd held");
endmodule
bind lane_config_register_bank bank_checker i_bank_checker (.*);
`default_nettype wire

// ==== verification/lane_config_register_bank_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module lane_config_register_bank_tb
    import lane_cfg_pkg::*;
;
    logic         mclk = 1'b0;
    logic         reset = 1'b1;
    logic         wr_en, rd_en, rd_hit;
    logic [7:0]   addr, wr_data, rd_data;
    logic [120:0] e;
    lane_ctrl_t   lane_ctrl;
    int           fail_count = 0, checked = 0, cyc = 0, seed = 70;
    always #25 mclk = ~mclk;
    lane_config_register_bank i_lane_config_register_bank (.*);
    spi_host i_spi_host (.*);
    task chk(input logic [120:0] s, x, input string n);
        checked++;
        if (s !== x)
        begin
            fail_count++;
            $display("BAD %s exp %h got %h", n, x, s);
        end
    endtask
    task finish_test;
        $display("checks %0d errors %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // each answer also shows the lane controls settled by then
    always @(posedge mclk)
        if (rd_en && !reset)
        begin
            @(negedge mclk);
            e = i_spi_host.exp_q.pop_front();
            chk({lane_ctrl, rd_hit, rd_data}, e, "rd");
        end
    always @(posedge mclk)
        if (++cyc == 1000)
        begin
            fail_count++;
            finish_test;
        end
    initial
    begin
        i_spi_host.clr();
        repeat (16) @(negedge mclk);
        reset = 1'b0;
        i_spi_host.xfer(1'b0, 8'h0E, 8'h00);
        for (int a = 2; a < 20; a++)
            i_spi_host.xfer(1'b1, 8'(a), 8'($random(seed)));
        for (int a = 2; a < 20; a++)
            i_spi_host.xfer(1'b0, 8'(a), 8'h00);
        for (int c = 0; c < 32; c++)
        begin
            i_spi_host.xfer(1'b1, 8'h0D, {c[4:0], 3'h5});
            i_spi_host.xfer(1'b0, 8'h0C, 8'h00);
        end
        reset = 1'b1;
        i_spi_host.clr();
        @(negedge mclk);
        reset = 1'b0;
        i_spi_host.xfer(1'b0, 8'h11, 8'h00);
        repeat (2) @(negedge mclk);
        finish_test;
    end
endmodule
`default_nettype wire

// ==== verification/spi_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module spi_host
    import lane_cfg_pkg::*;
(
    input  wire logic  mclk,
    output logic       wr_en,
    output logic       rd_en,
    output logic [7:0] addr,
    output logic [7:0] wr_data
);
    logic [111:0] mm;
    logic         h;
    logic [120:0] exp_q[$];
    initial {wr_en, rd_en, addr, wr_data} = 18'h0;
    task clr;
        mm = {32'h0, {LANES{EQ_RESET_CODE}}};
    endtask
    // one strobe a call; released lines show the inverse, not old values
    task xfer(input logic w, input logic [7:0] a, d);
        @(negedge mclk);
        {wr_en, rd_en, addr, wr_data} = {w, !w, a, d};
        h = a inside {[8'h04:8'h11]};
        if (w && h) mm[8*(a-4)+:8] = d;
        if (!w) exp_q.push_back({mm[79:0], mm[95:80], mm[111:96], h,
            h ? mm[8*(a-4)+:8] : 8'h00});
        @(negedge mclk);
        {wr_en, rd_en, addr, wr_data} = {2'h0, ~a, ~d};
    endtask
endmodule
`default_nettype wire
